// [inc/dsad_cfg.svh]
// Constants for the data space address decoder.
`ifndef DSAD_CFG_SVH
`define DSAD_CFG_SVH
`define DSAD_EA_WIDTH       16
`define DSAD_WORD_WIDTH     16
`define DSAD_WINDOW_BIT     15
`define DSAD_WORDS_SMALL    512
`define DSAD_WORDS_LARGE    1024
`define DSAD_PAGE_WIDTH     8
`define DSAD_PROG_WIDTH     16
`define DSAD_ZERO_WORD      16'h0000
`define DSAD_ZERO_BYTE      8'h00
`define DSAD_BYTE_BIT       0
`define DSAD_WORD_LSB       1
`define DSAD_BYTE_WIDTH     8
`define DSAD_PAGE_BIT       0
`define DSAD_LANES_NONE     2'h0
`define DSAD_LANES_LOW      2'h1
`define DSAD_LANES_HIGH     2'h2
`define DSAD_LANES_BOTH     2'h3
`endif

// [inc/dsad_pkg.sv]
// Types shared by the data space address decoder files.
package dsad_pkg;
    typedef logic [15:0] dsad_word_t;
    typedef logic [15:0] dsad_addr_t;
    typedef logic [1:0]  dsad_lanes_t;
endpackage

// [hw/dsad_ram.sv]
// Word-wide data RAM with byte-lane writes and a registered read port.
`timescale 1ns/1ps
`include "dsad_cfg.svh"
module dsad_ram #(
    parameter int DEPTH = 1024,
    parameter int AW    = 10
) (
    input  wire logic                    clock,
    input  wire logic                    rd_en,
    input  wire logic [AW-1:0]           rd_index,
    output logic      [15:0]             rd_data,
    input  wire logic [1:0]              wr_lanes,
    input  wire logic [AW-1:0]           wr_index,
    input  wire logic [15:0]             wr_data
);
    logic [15:0] mem [DEPTH];

    // Each byte lane writes on its own so the other byte keeps its value.
    always_ff @(posedge clock) begin
        if (wr_lanes[0]) begin
            mem[wr_index][`DSAD_BYTE_WIDTH-1:0] <= wr_data[`DSAD_BYTE_WIDTH-1:0];
        end
        if (wr_lanes[1]) begin
            mem[wr_index][`DSAD_WORD_WIDTH-1:`DSAD_BYTE_WIDTH] <=
                wr_data[`DSAD_WORD_WIDTH-1:`DSAD_BYTE_WIDTH];
        end
    end

    // Read data comes from a register; no reset so it maps onto block RAM.
    always_ff @(posedge clock) begin
        if (rd_en) begin
            rd_data <= mem[rd_index];
        end
    end
endmodule

// [hw/dsad_top.sv]
// Data space address decoder: RAM half, program window half, read and write ports.
//
// Function
// R01: Separate read and write address ports share one linear data space.
// R02: Effective addresses are sixteen bits, byte granular, sixty-four kilobytes.
// R03: Address bit fifteen low selects RAM, high selects program window.
// R04: RAM is 512 or 1024 words; reads beyond it return zero.
// R05: Storage is sixteen-bit words while addresses pick bytes.
// R06: Even address selects low byte, odd address selects high byte.
// R07: Window program address bit fifteen comes from page register bit zero.
// R08: Byte writes touch one lane; writes beyond RAM do nothing.
`timescale 1ns/1ps
`include "dsad_cfg.svh"
module dsad_top #(
    parameter int WORDS = `DSAD_WORDS_LARGE
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        rd_req,
    input  wire logic [15:0] rd_effective_address,
    input  wire logic        rd_byte,
    output logic             rd_valid,
    output logic      [15:0] rd_data,
    output logic             rd_from_window,
    input  wire logic        wr_req,
    input  wire logic [15:0] wr_effective_address,
    input  wire logic        wr_byte,
    input  wire logic [15:0] wr_data,
    input  wire logic [7:0]  program_window_page,
    output logic             window_req,
    output logic      [15:0] window_address,
    input  wire logic [15:0] window_data
);
    localparam int AW = $clog2(WORDS);

    // ------------------------------------------------------------
    // Read address decode
    // ------------------------------------------------------------
    // The word index drops the byte bit and the top bit picks RAM or window.
    // The in-range test looks at the whole lower half, so an address past the
    // RAM can never alias onto a low word through the cut RAM index.
    logic [`DSAD_WINDOW_BIT-`DSAD_WORD_LSB:0] rd_word;
    logic                                     rd_window;
    logic                                     rd_in_ram;
    logic                                     rd_odd;
    assign rd_word   = rd_effective_address[`DSAD_WINDOW_BIT:`DSAD_WORD_LSB]; // R02 R05
    assign rd_window = rd_effective_address[`DSAD_WINDOW_BIT]; // R03
    assign rd_odd    = rd_effective_address[`DSAD_BYTE_BIT]; // R06
    assign rd_in_ram = !rd_window && (32'(rd_word) < 32'(WORDS)); // R03 R04

    // ------------------------------------------------------------
    // Write address decode
    // ------------------------------------------------------------
    // Writes into the window half or past the RAM are dropped here, before the
    // RAM sees them, because the cut RAM index alone cannot tell them apart.
    logic [`DSAD_WINDOW_BIT-`DSAD_WORD_LSB:0] wr_word;
    logic                                     wr_window;
    logic                                     wr_in_ram;
    logic                                     wr_odd;
    assign wr_word   = wr_effective_address[`DSAD_WINDOW_BIT:`DSAD_WORD_LSB]; // R02 R05
    assign wr_window = wr_effective_address[`DSAD_WINDOW_BIT]; // R03
    assign wr_odd    = wr_effective_address[`DSAD_BYTE_BIT]; // R06
    assign wr_in_ram = !wr_window && (32'(wr_word) < 32'(WORDS)); // R03 R08

    // Byte lanes of a write: a word hits both, a byte only its own lane.
    dsad_pkg::dsad_lanes_t wr_lanes;
    always_comb begin
        wr_lanes = `DSAD_LANES_NONE;
        if (wr_req && wr_in_ram) begin // R08
            if (!wr_byte) begin
                wr_lanes = `DSAD_LANES_BOTH; // R05
            end else if (wr_odd) begin
                wr_lanes = `DSAD_LANES_HIGH; // R06
            end else begin
                wr_lanes = `DSAD_LANES_LOW; // R06
            end
        end
    end

    // A byte write carries its value in the low byte of the bus, so it is
    // copied onto both lanes and the lane enables pick where it lands.
    dsad_pkg::dsad_word_t wr_lane_data;
    always_comb begin
        if (wr_byte) begin
            wr_lane_data = {wr_data[`DSAD_BYTE_WIDTH-1:0], wr_data[`DSAD_BYTE_WIDTH-1:0]};
        end else begin
            wr_lane_data = wr_data;
        end
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // The RAM is only read for an in-range request, which saves power on
    // window reads and keeps the last RAM word on its output otherwise.
    dsad_pkg::dsad_word_t ram_q;
    dsad_ram #(
        .DEPTH (WORDS),
        .AW    (AW)
    ) u_ram (
        .clock    (clock),
        .rd_en    (rd_req && rd_in_ram),
        .rd_index (rd_word[AW-1:0]),
        .rd_data  (ram_q),
        .wr_lanes (wr_lanes),
        .wr_index (wr_word[AW-1:0]),
        .wr_data  (wr_lane_data)
    ); // R01 R05

    // ------------------------------------------------------------
    // Program window request
    // ------------------------------------------------------------
    // The window address takes bit fifteen from the page register, since the
    // top address bit is always set for a window read and carries nothing.
    logic window_hit;
    assign window_hit = rd_req && rd_window; // R03

    // One fetch pulse for each window read.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            window_req <= 1'b0;
        end else begin
            window_req <= window_hit; // R03
        end
    end

    // The address holds after the fetch, so the far side may sample it late.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            window_address <= `DSAD_ZERO_WORD;
        end else if (window_hit) begin
            window_address <= {program_window_page[`DSAD_PAGE_BIT],
                               rd_effective_address[`DSAD_WINDOW_BIT-1:0]}; // R07
        end
    end

    // ------------------------------------------------------------
    // Read pipeline state
    // ------------------------------------------------------------
    // First stage: the request marker, kept apart from the routing flags.
    logic p_valid;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            p_valid <= 1'b0;
        end else begin
            p_valid <= rd_req; // R01
        end
    end

    // Where the answer comes from, decided while the address still stands.
    logic p_ram;
    logic p_window;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            p_ram    <= 1'b0;
            p_window <= 1'b0;
        end else begin
            p_ram    <= rd_req && rd_in_ram; // R04
            p_window <= window_hit; // R03
        end
    end

    // Byte or word answer, and which lane a byte answer comes from.
    logic p_byte;
    logic p_odd;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            p_byte <= 1'b0;
            p_odd  <= 1'b0;
        end else begin
            p_byte <= rd_byte; // R05
            p_odd  <= rd_odd; // R06
        end
    end

    // ------------------------------------------------------------
    // Answer selection
    // ------------------------------------------------------------
    // RAM word, window word, or zero for space that holds no RAM.
    dsad_pkg::dsad_word_t word_sel;
    always_comb begin
        if (p_ram) begin
            word_sel = ram_q;
        end else if (p_window) begin
            word_sel = window_data; // R03
        end else begin
            word_sel = `DSAD_ZERO_WORD; // R04
        end
    end

    // A byte answer is zero-extended so software never sees the other lane.
    dsad_pkg::dsad_word_t        next_rd_data;
    logic [`DSAD_BYTE_WIDTH-1:0] byte_sel;
    always_comb begin
        if (p_odd) begin
            byte_sel = word_sel[`DSAD_WORD_WIDTH-1:`DSAD_BYTE_WIDTH]; // R06
        end else begin
            byte_sel = word_sel[`DSAD_BYTE_WIDTH-1:0]; // R06
        end
        if (p_byte) begin
            next_rd_data = {`DSAD_ZERO_BYTE, byte_sel}; // R06
        end else begin
            next_rd_data = word_sel; // R05
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // The answer pulse comes two edges after the request edge.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= p_valid; // R01
        end
    end

    // The window flag rides with the answer pulse and lasts one cycle.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_from_window <= 1'b0;
        end else begin
            rd_from_window <= p_valid && p_window; // R03
        end
    end

    // Read data stands until the next answer replaces it.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= `DSAD_ZERO_WORD;
        end else if (p_valid) begin
            rd_data <= next_rd_data; // R04 R06
        end
    end
endmodule

// [dv/dsad_top_properties.sv]
// Port checks for the data space decoder.
`timescale 1ns/1ps
module dsad_checker #(
    parameter int WORDS = 1024
) (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        rd_req,
    input wire logic [15:0] rd_effective_address,
    input wire logic        rd_byte,
    input wire logic        rd_valid,
    input wire logic [15:0] rd_data,
    input wire logic        rd_from_window,
    input wire logic [7:0]  program_window_page,
    input wire logic        window_req,
    input wire logic [15:0] window_address
);
    // ----
    // Read timing and routing
    // ----
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // A read is either a window read or a RAM read, by the top address bit.
    sequence s_win;
        rd_req && rd_effective_address[15];
    endsequence
    sequence s_ram;
        rd_req && !rd_effective_address[15];
    endsequence
    a_read_latency: assert property (rd_req |-> ##2 rd_valid)
        else $error("late answer");
    a_valid_cause: assert property (rd_valid |-> $past(rd_req, 2))
        else $error("stray answer");
    a_ram_no_fetch: assert property (s_ram |=> !window_req)
        else $error("ram read fetched");
    a_win_flag: assert property (s_win |-> ##2 rd_from_window)
        else $error("window flag missing");
    a_ram_flag: assert property (s_ram |-> ##2 !rd_from_window)
        else $error("window flag on ram");
    a_win_address: assert property (s_win |=> window_req && window_address ==
        {$past(program_window_page[0]), $past(rd_effective_address[14:0])})
        else $error("bad window address");
    a_byte_upper: assert property (rd_req && rd_byte |-> ##2 rd_data[15:8] == 8'h00)
        else $error("byte upper not zero");
    a_beyond_zero: assert property ((s_ram and (rd_effective_address[14:1] >= WORDS))
        |-> ##2 rd_data == 16'h0000) else $error("beyond ram not zero");
endmodule
bind dsad_top dsad_checker #(.WORDS(WORDS)) chk (.clock, .rst_n, .rd_req, .rd_effective_address,
    .rd_byte, .rd_valid, .rd_data, .rd_from_window, .program_window_page, .window_req,
    .window_address);

// [dv/dsad_window_model.sv]
// Program memory stand-in answering window fetches.
`timescale 1ns/1ps
module dsad_window_model (
    input  wire logic        clock,
    input  wire logic        window_req,
    input  wire logic [15:0] window_address,
    output logic      [15:0] window_data
);
    logic [15:0] held;
    // Outside a fetch the bus shows the inverse, so stale data never passes.
    assign window_data = window_req ? (window_address ^ 16'h5AC3) : ~held;
    // Remember the last word driven.
    always_ff @(posedge clock) if (window_req) held <= window_address ^ 16'h5AC3;
endmodule

// [dv/data_space_address_decode_tb.sv]
// Self-checking bench for the data space decoder.
`timescale 1ns/1ps
module data_space_address_decode_tb;
    localparam int W = 512;
    logic        clock = 0, rst_n = 0, rd_req = 0, rd_byte = 0, wr_req = 0, wr_byte = 0;
    logic [15:0] rd_address = 0, wr_address = 0, wr_data = 0, rd_data, win_a, win_d;
    logic [7:0]  page = 0;
    logic        rd_valid, win_r, rd_win;
    int          mismatches = 0, compares = 0;
    // Clock at 25 MHz.
    always #20 clock = ~clock;
    dsad_top #(.WORDS(W)) dut (.clock, .rst_n, .rd_req, .rd_effective_address(rd_address),
        .rd_byte, .rd_valid, .rd_data, .rd_from_window(rd_win), .wr_req,
        .wr_effective_address(wr_address),
        .wr_byte, .wr_data, .program_window_page(page), .window_req(win_r),
        .window_address(win_a), .window_data(win_d));
    dsad_window_model pm (.clock, .window_req(win_r), .window_address(win_a),
        .window_data(win_d));
    // ----
    // Tasks
    // ----
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // One compare of a settled output against its expected value.
    task automatic check(input string name, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, e, s);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic b, input logic [15:0] d);
        @(posedge clock);
        wr_req <= 1'h1;
        wr_address <= a;
        wr_byte <= b;
        wr_data <= d;
        @(posedge clock);
        wr_req <= 1'h0;
    endtask
    // The valid pulse and the data are compared here; the window flag is left to the checker.
    task automatic rd(input logic [15:0] a, input logic b, input logic [15:0] e);
        int i;
        @(posedge clock);
        rd_req <= 1'h1;
        rd_address <= a;
        rd_byte <= b;
        @(posedge clock);
        rd_req <= 1'h0;
        for (i = 0; i < 4 && rd_valid !== 1'h1; i++) begin
            @(posedge clock);
            #1;
        end
        compares++;
        if (rd_valid !== 1'h1 || rd_data !== e) begin
            mismatches++;
            $display("unexpected rd_data expected %h seen %h", e, rd_data);
            if (rd_valid !== 1'h1) wrap_up();
        end
    endtask
    task automatic t_lanes;
        wr(16'h0010, 1'h0, 16'h1234);
        rd(16'h0010, 1'h0, 16'h1234);
        rd(16'h0011, 1'h1, 16'h0012);
        wr(16'h0011, 1'h1, 16'h00AB);
        rd(16'h0010, 1'h0, 16'hAB34);
    endtask
    // A write past the RAM must not alias onto word zero through the cut index.
    task automatic t_limits;
        wr(16'(2 * W - 2), 1'h0, 16'hBEEF);
        rd(16'(2 * W - 2), 1'h0, 16'hBEEF);
        wr(16'h0000, 1'h0, 16'h0F0F);
        wr(16'(2 * W), 1'h0, 16'hFFFF);
        rd(16'h0000, 1'h0, 16'h0F0F);
        rd(16'(2 * W), 1'h0, 16'h0000);
        rd(16'(2 * W + 1), 1'h1, 16'h0000);
        wr(16'h8010, 1'h0, 16'h5555);
        rd(16'h0010, 1'h0, 16'hAB34);
    endtask
    task automatic t_window;
        @(posedge clock);
        page <= 8'h01;
        rd(16'h9234, 1'h0, 16'h9234 ^ 16'h5AC3);
        @(posedge clock);
        page <= 8'hFE;
        rd(16'h9234, 1'h0, 16'h1234 ^ 16'h5AC3);
    endtask
    // A reset in mid-run clears every registered output but leaves the RAM alone.
    task automatic t_reset;
        @(posedge clock);
        rst_n <= 1'h0;
        @(posedge clock);
        #1;
        check("rd_valid", 16'h0000, 16'(rd_valid));
        check("rd_from_window", 16'h0000, 16'(rd_win));
        check("window_req", 16'h0000, 16'(win_r));
        check("rd_data", 16'h0000, rd_data);
        check("window_address", 16'h0000, win_a);
        @(posedge clock);
        rst_n <= 1'h1;
    endtask
    // Both ports in one cycle; a read of the word being written sees the old value.
    task automatic t_dual;
        fork
            wr(16'h0020, 1'h0, 16'h7777);
            rd(16'h0010, 1'h0, 16'hAB34);
        join
        rd(16'h0020, 1'h0, 16'h7777);
        fork
            wr(16'h0010, 1'h0, 16'h4321);
            rd(16'h0010, 1'h0, 16'hAB34);
        join
        rd(16'h0010, 1'h0, 16'h4321);
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'h1;
        t_lanes();
        t_limits();
        t_window();
        t_reset();
        t_dual();
        wrap_up();
    end
endmodule
